// >>> pcs_pkg.sv
// What this block does
// - Keep a 15-bit counter; low byte is a register, upper bits come from the latch.
// - Every kind of reset clears the whole program counter.
// - Writing the counter low byte loads bits 14..8 from the high latch together.
// - Direct call loads low byte and bits 10..8 from operand, bits 14..11 from latch.
// - Computed call loads low byte from working register and high bits from the latch.
// - Relative jump by working register: counter becomes counter plus one plus unsigned W.
// - Relative jump by literal: counter becomes counter plus one plus signed operand.
// - Return stack has 16 entries of 15 bits, outside program and data space.
// - Push on calls and interrupt entry; pop on return, literal return, interrupt return.
// - Pushes and pops leave the counter high latch unchanged.
// - With fault reset off the stack is circular; the 17th push overwrites entry zero.
// - Overflow and underflow set their flags whether or not fault reset is enabled.
// - Top-of-stack low/high pair shows and writes the entry picked by the stack index.
// - Stack index is 5 bits so overflow and underflow can be represented.
// - Push increments index then writes; return reads entry then decrements index.
// - With fault reset on, overflow or underflow resets the device and sets the flag.
`default_nettype none

package pcs_pkg;
    localparam int          PC_W          = 15;
    localparam int          DEPTH         = 16;
    localparam int          IDX_W         = 5;
    localparam int          ADDR_W        = 12;
    // Register offsets
    localparam logic [11:0] OFS_CNT_LOW   = 12'hF82;
    localparam logic [11:0] OFS_CNT_LATCH = 12'hF8A;
    localparam logic [11:0] OFS_PWR_FLAGS = 12'hF96;
    localparam logic [11:0] OFS_STAT_SH   = 12'hFE4;
    localparam logic [11:0] OFS_WREG_SH   = 12'hFE5;
    localparam logic [11:0] OFS_BSR_SH    = 12'hFE6;
    localparam logic [11:0] OFS_LATCH_SH  = 12'hFE7;
    localparam logic [11:0] OFS_P0L_SH    = 12'hFE8;
    localparam logic [11:0] OFS_P0H_SH    = 12'hFE9;
    localparam logic [11:0] OFS_P1L_SH    = 12'hFEA;
    localparam logic [11:0] OFS_P1H_SH    = 12'hFEB;
    localparam logic [11:0] OFS_STK_IDX   = 12'hFED;
    localparam logic [11:0] OFS_TOS_LOW   = 12'hFEE;
    localparam logic [11:0] OFS_TOS_HIGH  = 12'hFEF;
    // Field positions in the power control flags register
    localparam int          FLG_OVF_BIT   = 7;
    localparam int          FLG_UNF_BIT   = 6;
    // Reset values, top stack index and interrupt vector
    localparam logic [14:0] PC_RST        = 15'h0000;
    localparam logic [4:0]  IDX_RST       = 5'h1F;
    localparam logic [4:0]  IDX_TOP       = 5'h0F;
    localparam logic [6:0]  LATCH_RST     = 7'h00;
    localparam logic [7:0]  BYTE_RST      = 8'h00;
    localparam logic [14:0] INT_VECTOR    = 15'h0004;
endpackage : pcs_pkg

`default_nettype wire

// >>> pcs_counter_stack.sv
`default_nettype none

module pcs_counter_stack #(
    parameter logic [14:0] VECTOR = pcs_pkg::INT_VECTOR
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // Configuration
    input  wire logic        stack_fault_reset_enable,
    // Register port
    input  wire logic [11:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Core operations, at most one per cycle
    input  wire logic        op_advance,
    input  wire logic        op_call,
    input  wire logic [10:0] call_target,
    input  wire logic        op_subroutine_via_working,
    input  wire logic        op_jump_relative_working,
    input  wire logic        op_jump_relative_literal,
    input  wire logic [8:0]  jump_offset,
    input  wire logic        op_return,
    input  wire logic        op_subroutine_exit_with_literal,
    input  wire logic        op_interrupt_exit,
    input  wire logic        op_interrupt,
    // Core register values
    input  wire logic [7:0]  working_in,
    input  wire logic [2:0]  status_in,
    input  wire logic [4:0]  bank_select_in,
    input  wire logic [15:0] pointer0_in,
    input  wire logic [15:0] pointer1_in,
    // Counter and restore outputs
    output logic      [14:0] program_counter,
    output logic      [6:0]  counter_high_latch,
    output logic             restore_valid,
    output logic      [7:0]  working_restore,
    output logic      [2:0]  status_restore,
    output logic      [4:0]  bank_select_restore,
    output logic      [15:0] pointer0_restore,
    output logic      [15:0] pointer1_restore,
    output logic             stack_fault_reset
);

    logic [14:0] pc_q;
    logic [14:0] pc_d;
    logic [6:0]  latch_q;
    logic [4:0]  idx_q;
    logic [4:0]  idx_d;
    logic [14:0] stack_q [pcs_pkg::DEPTH];
    logic        ovf_q;
    logic        unf_q;
    logic        fault_q;
    logic [2:0]  stat_sh_q;
    logic [7:0]  wreg_sh_q;
    logic [4:0]  bsr_sh_q;
    logic [6:0]  latch_sh_q;
    logic [15:0] p0_sh_q;
    logic [15:0] p1_sh_q;
    logic        restore_q;
    logic [7:0]  rdata_q;

    logic        push;
    logic        pop;
    logic        overflow;
    logic        underflow;
    logic        fault;
    logic [4:0]  push_idx;
    logic [14:0] pc_inc;
    logic [14:0] tos;
    logic        wr_low;
    logic        wr_latch;
    logic        wr_idx;
    logic        wr_top_lo;
    logic        wr_top_hi;

    assign push      = op_call | op_subroutine_via_working | op_interrupt;
    assign pop       = op_return | op_subroutine_exit_with_literal | op_interrupt_exit;
    assign push_idx  = idx_q + 5'h01;
    // An index above the top, short of the empty code, means a prior wrap
    assign overflow  = push & (idx_q == pcs_pkg::IDX_TOP);
    assign underflow = pop & (idx_q == pcs_pkg::IDX_RST);
    assign fault     = stack_fault_reset_enable & (overflow | underflow);
    assign pc_inc    = pc_q + 15'h0001;
    assign tos       = stack_q[idx_q[3:0]];

    assign wr_low    = reg_wr & (reg_addr == pcs_pkg::OFS_CNT_LOW);
    assign wr_latch  = reg_wr & (reg_addr == pcs_pkg::OFS_CNT_LATCH);
    assign wr_idx    = reg_wr & (reg_addr == pcs_pkg::OFS_STK_IDX);
    assign wr_top_lo = reg_wr & (reg_addr == pcs_pkg::OFS_TOS_LOW);
    assign wr_top_hi = reg_wr & (reg_addr == pcs_pkg::OFS_TOS_HIGH);

    // Next counter value; core operations win over a register write
    always_comb begin
        pc_d = pc_q;
        if (op_call) begin
            pc_d = {latch_q[6:3], call_target};
        end else if (op_subroutine_via_working) begin
            pc_d = {latch_q, working_in};
        end else if (op_jump_relative_working) begin
            pc_d = pc_inc + {7'h00, working_in};
        end else if (op_jump_relative_literal) begin
            pc_d = pc_inc + {{6{jump_offset[8]}}, jump_offset};
        end else if (pop) begin
            pc_d = tos;
        end else if (op_interrupt) begin
            pc_d = VECTOR;
        end else if (op_advance) begin
            pc_d = pc_inc;
        end else if (wr_low) begin
            pc_d = {latch_q, reg_wdata};
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst || fault) begin
            pc_q <= pcs_pkg::PC_RST;
        end else begin
            pc_q <= pc_d;
        end
    end

    // The latch only follows software writes, never the stack
    always_ff @(posedge mclk) begin
        if (sys_rst || fault) begin
            latch_q <= pcs_pkg::LATCH_RST;
        end else if (wr_latch) begin
            latch_q <= reg_wdata[6:0];
        end
    end

    always_comb begin
        idx_d = idx_q;
        if (push) begin
            idx_d = push_idx;
        end else if (pop) begin
            idx_d = idx_q - 5'h01;
        end else if (wr_idx) begin
            idx_d = reg_wdata[4:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst || fault) begin
            idx_q <= pcs_pkg::IDX_RST;
        end else begin
            idx_q <= idx_d;
        end
    end

    // Wrapping through the low four bits makes the stack circular
    genvar gi;
    generate
        for (gi = 0; gi < pcs_pkg::DEPTH; gi++) begin : g_entry
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    stack_q[gi] <= 15'h0000;
                end else if (push && !fault && push_idx[3:0] == gi) begin
                    stack_q[gi] <= op_interrupt ? pc_q : pc_inc;
                end else if (wr_top_lo && idx_q[3:0] == gi) begin
                    stack_q[gi] <= {stack_q[gi][14:8], reg_wdata};
                end else if (wr_top_hi && idx_q[3:0] == gi) begin
                    stack_q[gi] <= {reg_wdata[6:0], stack_q[gi][7:0]};
                end
            end
        end
    endgenerate

    // Flags survive the fault reset so software can see its cause; set beats clear
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ovf_q <= 1'b0;
            unf_q <= 1'b0;
        end else begin
            ovf_q <= overflow | (ovf_q & ~(reg_wr && reg_addr == pcs_pkg::OFS_PWR_FLAGS
                     && !reg_wdata[pcs_pkg::FLG_OVF_BIT]));
            unf_q <= underflow | (unf_q & ~(reg_wr && reg_addr == pcs_pkg::OFS_PWR_FLAGS
                     && !reg_wdata[pcs_pkg::FLG_UNF_BIT]));
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= fault;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            stat_sh_q  <= 3'h0;
            wreg_sh_q  <= pcs_pkg::BYTE_RST;
            bsr_sh_q   <= 5'h00;
            latch_sh_q <= pcs_pkg::LATCH_RST;
            p0_sh_q    <= 16'h0000;
            p1_sh_q    <= 16'h0000;
        end else if (op_interrupt) begin
            stat_sh_q  <= status_in;
            wreg_sh_q  <= working_in;
            bsr_sh_q   <= bank_select_in;
            latch_sh_q <= latch_q;
            p0_sh_q    <= pointer0_in;
            p1_sh_q    <= pointer1_in;
        end else if (reg_wr) begin
            if (reg_addr == pcs_pkg::OFS_STAT_SH) begin
                stat_sh_q <= reg_wdata[2:0];
            end else if (reg_addr == pcs_pkg::OFS_WREG_SH) begin
                wreg_sh_q <= reg_wdata;
            end else if (reg_addr == pcs_pkg::OFS_BSR_SH) begin
                bsr_sh_q <= reg_wdata[4:0];
            end else if (reg_addr == pcs_pkg::OFS_LATCH_SH) begin
                latch_sh_q <= reg_wdata[6:0];
            end else if (reg_addr == pcs_pkg::OFS_P0L_SH) begin
                p0_sh_q[7:0] <= reg_wdata;
            end else if (reg_addr == pcs_pkg::OFS_P0H_SH) begin
                p0_sh_q[15:8] <= reg_wdata;
            end else if (reg_addr == pcs_pkg::OFS_P1L_SH) begin
                p1_sh_q[7:0] <= reg_wdata;
            end else if (reg_addr == pcs_pkg::OFS_P1H_SH) begin
                p1_sh_q[15:8] <= reg_wdata;
            end
        end
    end

    // Restored values go back to the core; the live latch is never rewritten by a return
    always_ff @(posedge mclk) begin
        if (sys_rst || fault) begin
            restore_q <= 1'b0;
        end else begin
            restore_q <= op_interrupt_exit;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_q <= pcs_pkg::BYTE_RST;
        end else if (!reg_rd) begin
            rdata_q <= pcs_pkg::BYTE_RST;
        end else if (reg_addr == pcs_pkg::OFS_CNT_LOW) begin
            rdata_q <= pc_q[7:0];
        end else if (reg_addr == pcs_pkg::OFS_CNT_LATCH) begin
            rdata_q <= {1'b0, latch_q};
        end else if (reg_addr == pcs_pkg::OFS_PWR_FLAGS) begin
            rdata_q <= {ovf_q, unf_q, 6'h00};
        end else if (reg_addr == pcs_pkg::OFS_STAT_SH) begin
            rdata_q <= {5'h00, stat_sh_q};
        end else if (reg_addr == pcs_pkg::OFS_WREG_SH) begin
            rdata_q <= wreg_sh_q;
        end else if (reg_addr == pcs_pkg::OFS_BSR_SH) begin
            rdata_q <= {3'h0, bsr_sh_q};
        end else if (reg_addr == pcs_pkg::OFS_LATCH_SH) begin
            rdata_q <= {1'b0, latch_sh_q};
        end else if (reg_addr == pcs_pkg::OFS_P0L_SH) begin
            rdata_q <= p0_sh_q[7:0];
        end else if (reg_addr == pcs_pkg::OFS_P0H_SH) begin
            rdata_q <= p0_sh_q[15:8];
        end else if (reg_addr == pcs_pkg::OFS_P1L_SH) begin
            rdata_q <= p1_sh_q[7:0];
        end else if (reg_addr == pcs_pkg::OFS_P1H_SH) begin
            rdata_q <= p1_sh_q[15:8];
        end else if (reg_addr == pcs_pkg::OFS_STK_IDX) begin
            rdata_q <= {3'h0, idx_q};
        end else if (reg_addr == pcs_pkg::OFS_TOS_LOW) begin
            rdata_q <= tos[7:0];
        end else if (reg_addr == pcs_pkg::OFS_TOS_HIGH) begin
            rdata_q <= {1'b0, tos[14:8]};
        end else begin
            rdata_q <= pcs_pkg::BYTE_RST;
        end
    end

    assign reg_rdata           = rdata_q;
    assign program_counter     = pc_q;
    assign counter_high_latch  = latch_q;
    assign restore_valid       = restore_q;
    assign working_restore     = wreg_sh_q;
    assign status_restore      = stat_sh_q;
    assign bank_select_restore = bsr_sh_q;
    assign pointer0_restore    = p0_sh_q;
    assign pointer1_restore    = p1_sh_q;
    assign stack_fault_reset   = fault_q;

    property p_low_write;
        @(posedge mclk) disable iff (sys_rst)
        (wr_low && !push && !pop && !op_advance && !op_jump_relative_working
         && !op_jump_relative_literal) |=> pc_q == {$past(latch_q), $past(reg_wdata)};
    endproperty
    a_low_write: assert property (p_low_write) else $error("low byte write bad");

    property p_call;
        @(posedge mclk) disable iff (sys_rst)
        (op_call && !fault) |=> pc_q == {$past(latch_q[6:3]), $past(call_target)};
    endproperty
    a_call: assert property (p_call) else $error("call target bad");

    property p_via_working;
        @(posedge mclk) disable iff (sys_rst)
        (op_subroutine_via_working && !fault) |=> pc_q == {$past(latch_q), $past(working_in)};
    endproperty
    a_via_working: assert property (p_via_working) else $error("computed call bad");

    property p_jump_working;
        @(posedge mclk) disable iff (sys_rst)
        op_jump_relative_working |=> pc_q == $past(pc_q) + 15'h0001 + {7'h00, $past(working_in)};
    endproperty
    a_jump_working: assert property (p_jump_working) else $error("working jump bad");

    property p_jump_literal;
        @(posedge mclk) disable iff (sys_rst)
        op_jump_relative_literal |=> pc_q == $past(pc_q) + 15'h0001
            + {{6{$past(jump_offset[8])}}, $past(jump_offset)};
    endproperty
    a_jump_literal: assert property (p_jump_literal) else $error("literal jump bad");

    property p_call_return;
        @(posedge mclk) disable iff (sys_rst)
        ((op_call || op_subroutine_via_working) && !fault) ##1 (pop && !fault) |=>
            pc_q == $past(pc_q, 2) + 15'h0001;
    endproperty
    a_call_return: assert property (p_call_return) else $error("return address bad");

    property p_push_index;
        @(posedge mclk) disable iff (sys_rst)
        (push && !fault) |=> idx_q == $past(idx_q) + 5'h01;
    endproperty
    a_push_index: assert property (p_push_index) else $error("push index bad");

    property p_latch_kept;
        @(posedge mclk) disable iff (sys_rst)
        ((push || pop) && !fault && !wr_latch) |=> $stable(latch_q);
    endproperty
    a_latch_kept: assert property (p_latch_kept) else $error("latch moved by stack");

    property p_overflow_flag;
        @(posedge mclk) disable iff (sys_rst)
        overflow |=> ovf_q;
    endproperty
    a_overflow_flag: assert property (p_overflow_flag) else $error("overflow flag lost");

    property p_fault_reset;
        @(posedge mclk) disable iff (sys_rst)
        fault |=> stack_fault_reset && pc_q == 15'h0000 && idx_q == 5'h1F ##1 !stack_fault_reset;
    endproperty
    a_fault_reset: assert property (p_fault_reset) else $error("fault reset bad");

    property p_wrap;
        @(posedge mclk) disable iff (sys_rst)
        (overflow && !stack_fault_reset_enable) |=> idx_q == 5'h10
            && stack_q[0] == $past(pc_q) + {14'h0000, !$past(op_interrupt)};
    endproperty
    a_wrap: assert property (p_wrap) else $error("circular wrap bad");

    property p_reset_pc;
        @(posedge mclk) sys_rst |=> pc_q == 15'h0000;
    endproperty
    a_reset_pc: assert property (p_reset_pc) else $error("reset pc bad");

    c_overflow: cover property (@(posedge mclk) disable iff (sys_rst) overflow);
    c_underflow: cover property (@(posedge mclk) disable iff (sys_rst) underflow);
    c_intr_exit: cover property (@(posedge mclk) disable iff (sys_rst)
        op_interrupt ##[1:20] op_interrupt_exit);

endmodule : pcs_counter_stack

`default_nettype wire

// >>> pcs_core_model.sv
`default_nettype none

module pcs_core_model (
    // Operation strobes
    output logic        op_advance,
    output logic        op_call,
    output logic        op_subroutine_via_working,
    output logic        op_jump_relative_working,
    output logic        op_jump_relative_literal,
    output logic        op_return,
    output logic        op_subroutine_exit_with_literal,
    output logic        op_interrupt_exit,
    output logic        op_interrupt,
    // Operands and core register values
    output logic [10:0] call_target,
    output logic [8:0]  jump_offset,
    output logic [7:0]  working_in,
    output logic [2:0]  status_in,
    output logic [4:0]  bank_select_in,
    output logic [15:0] pointer0_in,
    output logic [15:0] pointer1_in
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        set(4'hF, 11'h000);
    end

    // Every strobe is rewritten on each call, so two ops can never overlap
    task automatic set(input logic [3:0] k, input logic [10:0] v);
        op_advance                      <= (k == 4'h0);
        op_call                         <= (k == 4'h1);
        op_subroutine_via_working       <= (k == 4'h2);
        op_jump_relative_working        <= (k == 4'h3);
        op_jump_relative_literal        <= (k == 4'h4);
        op_return                       <= (k == 4'h5);
        op_subroutine_exit_with_literal <= (k == 4'h6);
        op_interrupt_exit               <= (k == 4'h7);
        op_interrupt                    <= (k == 4'h8);
        // Idle cycles get fresh operands so stale values never look valid
        call_target                     <= v;
        jump_offset                     <= v[8:0];
        working_in                      <= v[7:0];
        status_in                       <= 3'($urandom);
        bank_select_in                  <= 5'($urandom);
        pointer0_in                     <= 16'($urandom);
        pointer1_in                     <= 16'($urandom);
    endtask : set
endmodule : pcs_core_model

`default_nettype wire

// >>> pcs_counter_stack_test.sv
`default_nettype none

module pcs_counter_stack_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [3:0]  ADV = 4'h0, CALL = 4'h1, CALLV = 4'h2, JRW = 4'h3, JRL = 4'h4;
    localparam logic [3:0]  RET = 4'h5, RETL = 4'h6, RETI = 4'h7, INTR = 4'h8, NOP = 4'hF;
    localparam logic [14:0] VEC = 15'h0123;
    logic        mclk, sys_rst, stack_fault_reset_enable, reg_wr, reg_rd, chk_pc;
    logic        rd_d = 1'b0, pc_d = 1'b0, stack_fault_reset, ovf_m, unf_m;
    logic        op_advance, op_call, op_subroutine_via_working, op_jump_relative_working;
    logic        op_jump_relative_literal, op_return, op_subroutine_exit_with_literal;
    logic        op_interrupt_exit, op_interrupt;
    logic [10:0] call_target;
    logic [8:0]  jump_offset;
    logic [7:0]  working_in, reg_wdata, reg_rdata, wsh_m;
    logic [2:0]  status_in;
    logic [4:0]  bank_select_in, idx_m;
    logic [15:0] pointer0_in, pointer1_in;
    logic [11:0] reg_addr;
    logic [14:0] program_counter, pc_m;
    logic [6:0]  counter_high_latch, latch_m;
    logic [14:0] stk_m [16];
    logic [7:0]  q_rd [$];
    logic [21:0] q_pc [$];
    logic [31:0] r;
    logic [11:0] ra [7] = '{12'hF82, 12'hF8A, 12'hFED, 12'hF96, 12'hFE5, 12'hFEC, 12'hFEE};
    int          n_mismatch = 0, n_tests = 0, n_flt = 0;

    pcs_core_model core_u (.op_advance, .op_call, .op_subroutine_via_working,
        .op_jump_relative_working, .op_jump_relative_literal, .op_return,
        .op_subroutine_exit_with_literal, .op_interrupt_exit, .op_interrupt, .call_target,
        .jump_offset, .working_in, .status_in, .bank_select_in, .pointer0_in, .pointer1_in);

    pcs_counter_stack #(.VECTOR(VEC)) dut_u (.mclk, .sys_rst, .stack_fault_reset_enable,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .op_advance, .op_call,
        .call_target, .op_subroutine_via_working, .op_jump_relative_working,
        .op_jump_relative_literal, .jump_offset, .op_return, .op_subroutine_exit_with_literal,
        .op_interrupt_exit, .op_interrupt, .working_in, .status_in, .bank_select_in,
        .pointer0_in, .pointer1_in, .program_counter, .counter_high_latch, .restore_valid(),
        .working_restore(), .status_restore(), .bank_select_restore(), .pointer0_restore(),
        .pointer1_restore(), .stack_fault_reset);

    initial begin
        mclk = 1'b0;
    end
    always #10 mclk = ~mclk;

    task automatic cmp(input string nm, input logic [21:0] e, input logic [21:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    task automatic test_done;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done

    function automatic logic [7:0] rd_exp(input logic [11:0] a);
        case (a)
            12'hF82: return pc_m[7:0];
            12'hF8A: return {1'b0, latch_m};
            12'hFED: return {3'h0, idx_m};
            12'hFEE: return stk_m[idx_m[3:0]][7:0];
            12'hFEF: return {1'b0, stk_m[idx_m[3:0]][14:8]};
            12'hF96: return {ovf_m, unf_m, 6'h00};
            12'hFE5: return wsh_m;
            default: return 8'h00;
        endcase
    endfunction : rd_exp

    // One cycle of bus and core traffic; the reference model advances alongside
    task automatic step(input logic [3:0] k, input logic [10:0] v, input logic wr,
                        input logic rd, input logic [11:0] a, input logic [7:0] d);
        logic [4:0] ni;
        logic       flt;
        logic       psh;
        ni  = idx_m + 5'h01;
        flt = 1'b0;
        psh = (k == CALL) || (k == CALLV) || (k == INTR);
        core_u.set(k, v);
        reg_wr    <= wr;
        reg_rd    <= rd;
        reg_addr  <= a;
        reg_wdata <= d;
        if (rd) q_rd.push_back(rd_exp(a));
        if (psh && idx_m == 5'h0F) begin
            ovf_m = 1'b1;
            flt   = stack_fault_reset_enable;
        end
        if (psh && !flt) begin
            stk_m[ni[3:0]] = (k == INTR) ? pc_m : pc_m + 15'h0001;
            idx_m          = ni;
        end
        if (k inside {RET, RETL, RETI}) begin
            if (idx_m == 5'h1F) begin
                unf_m = 1'b1;
                flt   = stack_fault_reset_enable;
            end
            pc_m  = stk_m[idx_m[3:0]];
            idx_m = idx_m - 5'h01;
        end
        case (k)
            ADV:     pc_m = pc_m + 15'h0001;
            CALL:    pc_m = {latch_m[6:3], v};
            CALLV:   pc_m = {latch_m, v[7:0]};
            JRW:     pc_m = pc_m + 15'h0001 + {7'h00, v[7:0]};
            JRL:     pc_m = pc_m + 15'h0001 + {{6{v[8]}}, v[8:0]};
            INTR:    pc_m = VEC;
            default: ;
        endcase
        if (k == INTR) wsh_m = v[7:0];
        if (wr) begin
            case (a)
                12'hF82: pc_m = {latch_m, d};
                12'hF8A: latch_m = d[6:0];
                12'hFED: idx_m = d[4:0];
                12'hFEE: stk_m[idx_m[3:0]][7:0] = d;
                12'hFEF: stk_m[idx_m[3:0]][14:8] = d[6:0];
                12'hF96: {ovf_m, unf_m} = {ovf_m & d[7], unf_m & d[6]};
                12'hFE5: wsh_m = d;
                default: ;
            endcase
        end
        if (flt) begin
            pc_m    = '0;
            latch_m = '0;
            idx_m   = 5'h1F;
        end
        chk_pc <= (k != NOP) && !flt;
        if ((k != NOP) && !flt) q_pc.push_back({pc_m, latch_m});
        @(posedge mclk);
    endtask : step

    task automatic op(input logic [3:0] k, input logic [10:0] v);
        step(k, v, 1'b0, 1'b0, 12'($urandom), 8'($urandom));
    endtask : op

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        step(NOP, 11'($urandom), 1'b1, 1'b0, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a);
        step(NOP, 11'($urandom), 1'b0, 1'b1, a, 8'($urandom));
    endtask : rd

    task automatic rst(input logic en);
        stack_fault_reset_enable <= en;
        sys_rst                  <= 1'b1;
        repeat (10) op(NOP, 11'($urandom));
        sys_rst <= 1'b0;
        {pc_m, latch_m, idx_m, ovf_m, unf_m, wsh_m} = {22'h0, 5'h1F, 10'h0};
        foreach (stk_m[i]) stk_m[i] = '0;
    endtask : rst

    always @(posedge mclk) begin
        rd_d <= reg_rd;
        pc_d <= chk_pc;
        if (stack_fault_reset === 1'b1) n_flt++;
    end

    always @(negedge mclk) begin
        if (rd_d) cmp("reg_rdata", {14'h0, q_rd.pop_front()}, {14'h0, reg_rdata});
        if (pc_d) cmp("pc_latch", q_pc.pop_front(), {program_counter, counter_high_latch});
    end

    initial begin
        repeat (3000) @(posedge mclk);
        n_mismatch++;
        test_done();
    end

    initial begin
        {sys_rst, stack_fault_reset_enable, reg_wr, reg_rd, chk_pc} = 5'b10000;
        {reg_addr, reg_wdata} = 20'h0;
        r = $urandom(32'h0592);
        rst(1'b0);
        foreach (ra[i]) rd(ra[i]);
        repeat (4) begin
            r = $urandom;
            wr(12'hF8A, r[7:0]);
            wr(12'hF82, r[15:8]);
            op(ADV, 11'($urandom));
            op(CALL, r[26:16]);
            for (int j = 0; j < 3; j++) rd(12'hFED + 12'(j));
            op(CALLV, r[31:21]);
            op(RETL, 11'($urandom));
            op(RET, 11'($urandom));
            op(JRW, r[10:0]);
            op(JRL, r[20:10]);
        end
        // Offsets that carry across a 256-word block and the most negative literal
        wr(12'hF82, 8'hF0);
        op(JRW, 11'h0FF);
        op(JRL, 11'h100);
        op(INTR, 11'($urandom));
        rd(12'hFE5);
        op(RETI, 11'($urandom));
        repeat (17) op(CALL, 11'($urandom));
        rd(12'hF96);
        for (int j = 0; j < 3; j++) rd(12'hFED + 12'(j));
        wr(12'hFED, 8'h03);
        wr(12'hFEE, 8'($urandom));
        wr(12'hFEF, 8'($urandom));
        for (int j = 0; j < 3; j++) rd(12'hFED + 12'(j));
        op(RET, 11'($urandom));
        wr(12'hF96, 8'h00);
        rd(12'hF96);
        rst(1'b1);
        repeat (17) op(CALL, 11'($urandom));
        repeat (2) op(NOP, 11'($urandom));
        foreach (ra[i]) rd(ra[i]);
        wr(12'hF96, 8'h00);
        op(RET, 11'($urandom));
        repeat (2) op(NOP, 11'($urandom));
        rd(12'hF96);
        rd(12'hFED);
        wr(12'hF8A, 8'h7F);
        op(ADV, 11'($urandom));
        rst(1'b0);
        foreach (ra[i]) rd(ra[i]);
        repeat (2) op(NOP, 11'($urandom));
        cmp("fault_pulses", 22'd2, 22'(n_flt));
        test_done();
    end
endmodule : pcs_counter_stack_test

`default_nettype wire
